// ---- include/fspg_map.svh ----
// fspg_map.svh: address map, lock encodings and timing counts of the self-program guard
// assumes word addressing of a 64K-word flash; boot size from a two-bit fuse code
`ifndef FSPG_MAP_SVH
`define FSPG_MAP_SVH
`define FSPG_ADDR_W 16
`define FSPG_FLASH_TOP 16'hFFFF
// first word of the stalling region; boot area always at or above it
`define FSPG_STALL_BASE 16'hF000
// boot area start per boot-size fuse code
`define FSPG_BOOT_BASE_0 16'hF000
`define FSPG_BOOT_BASE_1 16'hF800
`define FSPG_BOOT_BASE_2 16'hFC00
`define FSPG_BOOT_BASE_3 16'hFE00
`define FSPG_LOCK_FREE 2'h3
`define FSPG_LOCK_NOSTORE 2'h2
`define FSPG_LOCK_ALL 2'h0
`define FSPG_LOCK_NOLOAD 2'h1
`define FSPG_ARM_WINDOW 3'h4
`define FSPG_OP_TIME_NS 4000000
`define FSPG_CLK_NS 4
`endif

// ---- include/fspg_pkg.sv ----
// fspg_pkg: types shared by the guard and its lock-decode helper
// assumes the map header is on the include path
package fspg_pkg;
	typedef enum logic [1:0] {fspg_op_none, fspg_op_erase, fspg_op_write, fspg_op_lock} fspg_op_e;
	typedef logic [1:0] fspg_lock_t;
endpackage

// ---- include/fspg_lock_if.sv ----
// fspg_lock_if: lock pair decode carried between guard and helper
// assumes both ends in one clock domain
`timescale 1ns/1ps
interface fspg_lock_if;
	logic [1:0] app_lock;
	logic [1:0] boot_lock;
	logic app_no_store;
	logic app_no_load;
	logic boot_no_store;
	logic boot_no_load;
	modport dec (input app_lock, input boot_lock, output app_no_store, output app_no_load,
		output boot_no_store, output boot_no_load);
	modport use_side (output app_lock, output boot_lock, input app_no_store, input app_no_load,
		input boot_no_store, input boot_no_load);
endinterface

// ---- hdl/fspg_lock_decode.sv ----
// fspg_lock_decode: turns the two lock-bit pairs into restriction flags
// assumes bit high = unprogrammed, pairs arrive registered
`timescale 1ns/1ps
`include "fspg_map.svh"
module fspg_lock_decode (
	fspg_lock_if.dec lk
);
	// store barred in modes 2 and 3, load barred in modes 3 and 4
	function automatic logic no_store(input fspg_pkg::fspg_lock_t m);
		no_store = (m == `FSPG_LOCK_NOSTORE) || (m == `FSPG_LOCK_ALL);
	endfunction
	function automatic logic no_load(input fspg_pkg::fspg_lock_t m);
		no_load = (m == `FSPG_LOCK_ALL) || (m == `FSPG_LOCK_NOLOAD);
	endfunction
	// one-valued bits mean unrestricted
	assign lk.app_no_store = no_store(lk.app_lock); // [RULE13] [RULE15]
	assign lk.app_no_load = no_load(lk.app_lock); // [RULE16]
	assign lk.boot_no_store = no_store(lk.boot_lock); // [RULE19]
	assign lk.boot_no_load = no_load(lk.boot_lock); // [RULE20]
endmodule

// ---- hdl/fspg_guard.sv ----
// fspg_guard: access guard and read-while-write arbitration for flash self-programming
// How it works
// [RULE1] no programming from application area stores
// [RULE2] boot-area stores may program any page
// [RULE3] boot fuses set boundary; separate lock pairs
// [RULE4] concurrent-region op leaves core running
// [RULE5] stalling-region op halts core, no reads
// [RULE6] concurrent region reads invalid during programming
// [RULE7] busy flag high while concurrent region blocked
// [RULE8] busy stays set until software clears it
// [RULE9] boot area lies inside stalling region
// [RULE10] lock bits only programmed; chip erase resets
// [RULE11] general lock mode 2 ignored here
// [RULE12] general lock mode 3 ignored here
// [RULE13] lock bit one unprogrammed; both one free
// [RULE14] app mode 1 allows all accesses
// [RULE15] app modes 2,3 block stores to app
// [RULE16] app modes 3,4 block boot loads
// [RULE17] app modes 3,4 mask interrupts when needed
// [RULE18] boot mode 1 allows all accesses
// [RULE19] boot modes 2,3 block stores to boot
// [RULE20] boot modes 3,4 block application loads
// [RULE21] boot modes 3,4 mask interrupts when needed
// [RULE22] store must follow arming within four cycles
// [RULE23] check target and executing area; blocked is inert
// assumes core, flash macro and this guard share clock; op completion timed by an internal cycle counter
`timescale 1ns/1ps
`include "fspg_map.svh"
module fspg_guard #(
	parameter int OP_CYCLES = `FSPG_OP_TIME_NS / `FSPG_CLK_NS
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [1:0] boot_size_fuses,
	input wire logic chip_erase,
	input wire logic ext_lock_write,
	input wire logic [3:0] ext_lock_value,
	input wire logic [1:0] general_lock_mode,
	input wire logic ctrl_write,
	input wire fspg_pkg::fspg_op_e ctrl_op,
	input wire logic [3:0] ctrl_lock_value,
	input wire logic busy_clear,
	input wire logic program_store_instr,
	input wire logic [15:0] store_addr,
	input wire logic [15:0] exec_addr,
	input wire logic load_req,
	input wire logic [15:0] load_addr,
	input wire logic fetch_req,
	input wire logic [15:0] fetch_addr,
	input wire logic irq_vectors_in_boot,
	input wire logic irq_req,
	output logic core_halt,
	output logic concurrent_region_busy_flag,
	output logic prog_busy,
	output logic op_start,
	output logic op_erase,
	output logic [15:0] op_addr,
	output logic store_refused,
	output logic load_grant,
	output logic load_refused,
	output logic fetch_valid,
	output logic irq_allow,
	output logic app_lock_bit_high,
	output logic app_lock_bit_low,
	output logic boot_lock_bit_high,
	output logic boot_lock_bit_low
);
	typedef enum logic [1:0] {st_idle, st_run_concurrent, st_run_stall} fspg_state_e;
	fspg_state_e state;
	fspg_state_e next_state;
	logic [1:0] app_lock;
	logic [1:0] boot_lock;
	logic [2:0] arm_count;
	fspg_pkg::fspg_op_e armed_op;
	logic [3:0] armed_lock;
	logic [$clog2(OP_CYCLES+1)-1:0] op_count;
	logic [15:0] boot_base;
	logic store_ok;
	logic tgt_boot;
	logic exe_boot;
	logic load_exe_boot;
	logic load_tgt_boot;
	logic exec_in_boot;
	logic fire;
	logic load_bar;
	fspg_lock_if lk ();

	fspg_lock_decode u_dec (
		.lk(lk)
	);
	assign lk.app_lock = app_lock;
	assign lk.boot_lock = boot_lock;

	// area test used for target and executing addresses alike
	function automatic logic in_boot(input logic [15:0] a, input logic [15:0] base);
		in_boot = (a >= base);
	endfunction
	function automatic logic in_stall(input logic [15:0] a);
		in_stall = (a >= `FSPG_STALL_BASE);
	endfunction

	// concurrent-region reads stay invalid until software clears the busy flag
	function automatic logic conc_blocked(input logic busy, input logic [15:0] a);
		conc_blocked = busy && !in_stall(a);
	endfunction

	// boot boundary from fuses; every choice sits at or above the stalling base
	always_comb
	begin
		case (boot_size_fuses)
			2'h0: boot_base = `FSPG_BOOT_BASE_0; // [RULE3] [RULE9]
			2'h1: boot_base = `FSPG_BOOT_BASE_1;
			2'h2: boot_base = `FSPG_BOOT_BASE_2;
			default: boot_base = `FSPG_BOOT_BASE_3;
		endcase
	end

	// area classification of the store and load requests
	assign tgt_boot = in_boot(store_addr, boot_base); // [RULE23]
	assign exe_boot = in_boot(exec_addr, boot_base); // [RULE1] [RULE23]
	assign load_exe_boot = exe_boot;
	assign load_tgt_boot = in_boot(load_addr, boot_base);
	assign exec_in_boot = exe_boot;

	// a load across areas answers to the lock pair of the area being read
	assign load_bar = (load_exe_boot && !load_tgt_boot && lk.app_no_load)
		|| (!load_exe_boot && load_tgt_boot && lk.boot_no_load); // [RULE16] [RULE20]

	// store permitted only from boot, only while armed; page stores only if the target pair allows it;
	// general lock mode is deliberately not consulted
	always_comb
	begin
		store_ok = 1'b0;
		if (exe_boot && (arm_count != 3'h0) && (state == st_idle)) // [RULE1] [RULE22]
		begin
			if (armed_op == fspg_pkg::fspg_op_lock)
				store_ok = 1'b1;
			else if (armed_op != fspg_pkg::fspg_op_none)
				store_ok = tgt_boot ? !lk.boot_no_store : !lk.app_no_store; // [RULE2] [RULE11] [RULE14] [RULE18]
		end
	end
	// lock-bit stores touch no page, so they never start the sequencer
	assign fire = program_store_instr && store_ok;

	// arming window: opens on control write, closes after four cycles or a store
	// a store in the very cycle of the control write is not taken; window opens one edge later
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			arm_count <= 3'h0;
			armed_op <= fspg_pkg::fspg_op_none;
			armed_lock <= {`FSPG_LOCK_FREE, `FSPG_LOCK_FREE};
		end
		else if (ctrl_write)
		begin
			arm_count <= `FSPG_ARM_WINDOW; // [RULE22]
			armed_op <= ctrl_op;
			armed_lock <= ctrl_lock_value;
		end
		else if (program_store_instr || arm_count != 3'h0)
		begin
			arm_count <= program_store_instr ? 3'h0 : arm_count - 3'h1; // [RULE22]
		end
	end

	// lock bits: only cleared bits stick until chip erase; reset keeps them (nonvolatile)
	// no rst branch on purpose: a system reset must not reopen a locked area
	always_ff @(posedge clock)
	begin
		if (chip_erase)
		begin
			app_lock <= `FSPG_LOCK_FREE; // [RULE10]
			boot_lock <= `FSPG_LOCK_FREE;
		end
		else if (ext_lock_write)
		begin
			app_lock <= app_lock & ext_lock_value[1:0]; // [RULE10]
			boot_lock <= boot_lock & ext_lock_value[3:2];
		end
		else if (fire && armed_op == fspg_pkg::fspg_op_lock)
		begin
			app_lock <= app_lock & armed_lock[1:0]; // [RULE10]
			boot_lock <= boot_lock & armed_lock[3:2];
		end
	end

	// operation sequencer: region of the target picks stall or concurrent
	always_comb
	begin
		next_state = state;
		case (state)
			st_idle:
				if (fire && armed_op != fspg_pkg::fspg_op_lock)
					next_state = in_stall(store_addr) ? st_run_stall : st_run_concurrent; // [RULE4] [RULE5]
			st_run_concurrent, st_run_stall:
				if (op_count == '0)
					next_state = st_idle;
			default: next_state = st_idle;
		endcase
	end
	always_ff @(posedge clock)
	begin
		if (rst)
			state <= st_idle;
		else
			state <= next_state;
	end

	// duration counter of the flash operation
	always_ff @(posedge clock)
	begin
		if (rst)
			op_count <= '0;
		else if (state == st_idle && next_state != st_idle)
			op_count <= ($clog2(OP_CYCLES+1))'(OP_CYCLES - 1);
		else if (op_count != '0)
			op_count <= op_count - 1'b1;
	end

	// flash command strobe and latched address
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			op_start <= 1'b0;
			op_erase <= 1'b0;
			op_addr <= 16'h0000;
			store_refused <= 1'b0;
		end
		else
		begin
			op_start <= state == st_idle && next_state != st_idle;
			store_refused <= program_store_instr && !store_ok; // [RULE23]
			if (state == st_idle && next_state != st_idle)
			begin
				op_erase <= armed_op == fspg_pkg::fspg_op_erase;
				op_addr <= store_addr;
			end
		end
	end

	// halt for stalling-region ops; busy flag sticky until software clear, set wins
	// driven from next_state so the halt is up in the very cycle the op starts
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			core_halt <= 1'b0;
			prog_busy <= 1'b0;
			concurrent_region_busy_flag <= 1'b0;
		end
		else
		begin
			core_halt <= next_state == st_run_stall; // [RULE5]
			prog_busy <= next_state != st_idle;
			if (next_state != st_idle)
				concurrent_region_busy_flag <= 1'b1; // [RULE7] [RULE8]
			else if (busy_clear)
				concurrent_region_busy_flag <= 1'b0; // [RULE8]
		end
	end

	// reads: nothing during stall op; concurrent region invalid while busy flag set
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			load_grant <= 1'b0;
			load_refused <= 1'b0;
			fetch_valid <= 1'b0;
		end
		else
		begin
			// general mode 3 has no say over core loads
			load_grant <= load_req && !load_bar // [RULE16] [RULE20] [RULE12]
				&& state != st_run_stall
				&& !conc_blocked(concurrent_region_busy_flag, load_addr); // [RULE6]
			load_refused <= load_req && load_bar; // [RULE23]
			fetch_valid <= fetch_req && state != st_run_stall // [RULE5]
				&& !conc_blocked(concurrent_region_busy_flag, fetch_addr); // [RULE4] [RULE6]
		end
	end

	// interrupt gating when vectors live in the other area and the executing area is load-locked
	always_ff @(posedge clock)
	begin
		if (rst)
			irq_allow <= 1'b0;
		else
			irq_allow <= irq_req
				&& !(irq_vectors_in_boot && !exec_in_boot && lk.app_no_load) // [RULE17]
				&& !(!irq_vectors_in_boot && exec_in_boot && lk.boot_no_load); // [RULE21]
	end

	// lock bit view for status; registered copy of the lock flops, one cycle behind
	always_ff @(posedge clock)
	begin
		app_lock_bit_high <= app_lock[1];
		app_lock_bit_low <= app_lock[0];
		boot_lock_bit_high <= boot_lock[1];
		boot_lock_bit_low <= boot_lock[0];
	end
endmodule

// ---- tb/fspg_guard_monitor.sv ----
// fspg_guard_monitor: port-level assertions for the self-program guard
// assumes it is bound onto fspg_guard; one clock, sync reset
`timescale 1ns/1ps
`include "fspg_map.svh"
module fspg_guard_monitor (
	input wire logic clock,
	input wire logic rst,
	input wire logic [1:0] boot_size_fuses,
	input wire logic busy_clear,
	input wire logic program_store_instr,
	input wire logic [15:0] store_addr,
	input wire logic [15:0] exec_addr,
	input wire logic load_req,
	input wire logic [15:0] load_addr,
	input wire logic fetch_req,
	input wire logic [15:0] fetch_addr,
	input wire logic irq_vectors_in_boot,
	input wire logic irq_req,
	input wire logic core_halt,
	input wire logic concurrent_region_busy_flag,
	input wire logic op_start,
	input wire logic [15:0] op_addr,
	input wire logic store_refused,
	input wire logic load_refused,
	input wire logic fetch_valid,
	input wire logic irq_allow,
	input wire logic app_lock_bit_high,
	input wire logic app_lock_bit_low
);
	logic [15:0] base;
	// boot area start; everything below is application area
	assign base = boot_size_fuses == 2'h0 ? `FSPG_BOOT_BASE_0 : boot_size_fuses == 2'h1 ?
		`FSPG_BOOT_BASE_1 : boot_size_fuses == 2'h2 ? `FSPG_BOOT_BASE_2 : `FSPG_BOOT_BASE_3;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_app_store;
		program_store_instr && exec_addr < base;
	endsequence
	sequence s_rww_start;
		op_start && op_addr < `FSPG_STALL_BASE;
	endsequence
	sequence s_stall_start;
		op_start && op_addr >= `FSPG_STALL_BASE;
	endsequence
	a_app_store_refused: assert property (s_app_store |=> store_refused && !op_start)
		else $error("store from application area started an op");
	a_store_lock_app: assert property (program_store_instr && exec_addr >= base
		&& store_addr < base && !app_lock_bit_low |=> !op_start)
		else $error("locked application page was programmed");
	a_rww_keeps_running: assert property (s_rww_start |-> !core_halt
		&& concurrent_region_busy_flag)
		else $error("concurrent op halted core or left flag low");
	a_stall_halts_core: assert property (s_stall_start |-> core_halt)
		else $error("stalling region op did not halt core");
	a_flag_stays_set: assert property (concurrent_region_busy_flag && !busy_clear
		|=> concurrent_region_busy_flag)
		else $error("busy flag dropped without clear");
	a_conc_fetch_blocked: assert property (fetch_req && fetch_addr < `FSPG_STALL_BASE
		&& concurrent_region_busy_flag |=> !fetch_valid)
		else $error("concurrent region fetch valid while busy");
	a_load_lock_app: assert property (load_req && exec_addr >= base && load_addr < base
		&& !app_lock_bit_high |=> load_refused)
		else $error("locked application load not refused");
	a_irq_gated: assert property (irq_req && irq_vectors_in_boot && exec_addr < base
		&& !app_lock_bit_high |=> !irq_allow)
		else $error("interrupt allowed in locked application area");
	a_halt_no_fetch: assert property (core_halt && fetch_req |=> !fetch_valid)
		else $error("fetch answered while core halted");
	a_start_sets_flag: assert property (op_start |-> concurrent_region_busy_flag)
		else $error("operation started with busy flag low");
endmodule
bind fspg_guard fspg_guard_monitor fspg_guard_monitor_inst (.*);

// ---- tb/fspg_core_model.sv ----
// fspg_core_model: boot-loader core issuing arm, store and program counter
// assumes the guard samples on the rising clock edge
`timescale 1ns/1ps
module fspg_core_model (
	input wire logic clock,
	output logic ctrl_write = 1'b0,
	output fspg_pkg::fspg_op_e ctrl_op = fspg_pkg::fspg_op_none,
	output logic [3:0] ctrl_lock_value = 4'hF,
	output logic program_store_instr = 1'b0,
	output logic [15:0] store_addr = 16'h0000,
	output logic [15:0] exec_addr = 16'hF800
);
	// jump the program counter
	task automatic at(input logic [15:0] ex);
		@(posedge clock);
		exec_addr <= ex;
	endtask
	// arm, then store gap edges later; gap 5 misses the window on purpose
	task automatic store(input fspg_pkg::fspg_op_e op, input logic [15:0] ta,
		input logic [15:0] ex, input int gap);
		@(posedge clock);
		ctrl_write <= 1'b1;
		ctrl_op <= op;
		exec_addr <= ex;
		@(posedge clock);
		ctrl_write <= 1'b0;
		ctrl_op <= fspg_pkg::fspg_op_none;
		repeat (gap - 1) @(posedge clock);
		program_store_instr <= 1'b1;
		store_addr <= ta;
		@(posedge clock);
		program_store_instr <= 1'b0;
		store_addr <= ~ta; // released address must not linger
	endtask
	// arm a lock-bit store and issue it at the first edge of the window
	task automatic lock_store(input logic [3:0] v, input logic [15:0] ex);
		@(posedge clock);
		ctrl_write <= 1'b1;
		ctrl_op <= fspg_pkg::fspg_op_lock;
		ctrl_lock_value <= v;
		exec_addr <= ex;
		@(posedge clock);
		ctrl_write <= 1'b0;
		ctrl_op <= fspg_pkg::fspg_op_none;
		ctrl_lock_value <= 4'hF;
		program_store_instr <= 1'b1;
		@(posedge clock);
		program_store_instr <= 1'b0;
	endtask
endmodule

// ---- tb/fspg_guard_tb.sv ----
// fspg_guard_tb: random and corner tests of the self-program guard
// assumes the core model drives arm, store and program counter
`timescale 1ns/1ps
`include "fspg_map.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module fspg_guard_tb;
	localparam int OPC = 8;
	logic clock = 0, rst = 1, chip_erase = 0, ext_lock_write = 0, busy_clear = 0;
	logic load_req = 0, fetch_req = 0, irq_vectors_in_boot = 0, irq_req = 0;
	logic [1:0] boot_size_fuses = 0, general_lock_mode = 0, lv;
	logic [3:0] ext_lock_value = 0, ctrl_lock_value;
	logic [15:0] load_addr = 0, fetch_addr = 0, store_addr, exec_addr, op_addr, ta;
	logic ctrl_write, program_store_instr, core_halt, concurrent_region_busy_flag, prog_busy;
	logic op_start, op_erase, store_refused, load_grant, load_refused, fetch_valid, irq_allow;
	logic app_lock_bit_high, app_lock_bit_low, boot_lock_bit_high, boot_lock_bit_low;
	fspg_pkg::fspg_op_e ctrl_op;
	logic [3:0] locks;
	assign locks = {boot_lock_bit_high, boot_lock_bit_low, app_lock_bit_high, app_lock_bit_low};
	int failures = 0, check_count = 0;
	fspg_guard #(.OP_CYCLES(OPC)) fspg_guard_inst (.*);
	fspg_core_model fspg_core_model_inst (.*);
	// core clock, 4 ns period
	always #2 clock = ~clock;
	// expected boot area start per fuse code
	function automatic logic [15:0] base(logic [1:0] f);
		return f == 2'h0 ? `FSPG_BOOT_BASE_0 : f == 2'h1 ? `FSPG_BOOT_BASE_1 :
			f == 2'h2 ? `FSPG_BOOT_BASE_2 : `FSPG_BOOT_BASE_3;
	endfunction
	// arm and store, then look at the registered answer
	task automatic st(fspg_pkg::fspg_op_e op, logic [15:0] t, ex, int gap, logic ok, string n);
		fspg_core_model_inst.store(op, t, ex, gap);
		#1;
		`CHK(n, ok, op_start)
		`CHK(n, !ok, store_refused)
		if (ok)
			`CHK(n, op == fspg_pkg::fspg_op_erase, op_erase)
	endtask
	// op runs out, flag stays until cleared
	task automatic fin();
		repeat (OPC + 2) @(posedge clock);
		#1;
		`CHK("op end", 1'b0, prog_busy)
		`CHK("flag held", 1'b1, concurrent_region_busy_flag)
		@(posedge clock);
		busy_clear <= 1;
		@(posedge clock);
		busy_clear <= 0;
		#1;
		`CHK("flag cleared", 1'b0, concurrent_region_busy_flag)
	endtask
	// one fetch or load; answer one cycle later
	task automatic rd(logic ld, logic [15:0] a, logic ok, string n);
		@(posedge clock);
		load_req <= ld;
		fetch_req <= !ld;
		load_addr <= a;
		fetch_addr <= a;
		@(posedge clock);
		load_req <= 0;
		fetch_req <= 0;
		load_addr <= ~a;
		fetch_addr <= ~a;
		#1;
		`CHK(n, ok, ld ? load_grant && !load_refused : fetch_valid)
	endtask
	// chip erase, then program a lock pattern
	task automatic lock(logic [3:0] v);
		@(posedge clock);
		chip_erase <= 1;
		@(posedge clock);
		chip_erase <= 0;
		ext_lock_write <= 1;
		ext_lock_value <= v;
		@(posedge clock);
		ext_lock_write <= 0;
		repeat (2) @(posedge clock);
		#1;
		`CHK("locks", v, locks)
	endtask
	// interrupt request from a given area
	task automatic irq(logic vb, logic [15:0] ex, logic ok, string n);
		fspg_core_model_inst.at(ex);
		irq_vectors_in_boot <= vb;
		irq_req <= 1;
		repeat (2) @(posedge clock);
		#1;
		`CHK(n, ok, irq_allow)
		@(posedge clock);
		irq_req <= 0;
	endtask
	// lock pattern through an armed store; only boot code may set it
	task automatic slock(logic [3:0] v, logic [15:0] ex, logic [3:0] exp, string n);
		fspg_core_model_inst.lock_store(v, ex);
		#1;
		`CHK(n, 1'b0, op_start)
		`CHK(n, ex < base(boot_size_fuses), store_refused)
		@(posedge clock);
		#1;
		`CHK(n, exp, locks)
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// main sequence
	initial
	begin
		void'($urandom(32'h9DEF1056));
		repeat (12) @(posedge clock);
		rst <= 0;
		lock(4'hF);
		ta = 16'($urandom_range(0, 16'hEFFF));
		st(fspg_pkg::fspg_op_erase, ta, 16'hF800, 1, 1, "rww erase");
		`CHK("no halt", 1'b0, core_halt)
		`CHK("op addr", ta, op_addr)
		// a clear during the operation loses to the set
		@(posedge clock);
		busy_clear <= 1;
		@(posedge clock);
		busy_clear <= 0;
		#1;
		`CHK("clear in op", 1'b1, concurrent_region_busy_flag)
		st(fspg_pkg::fspg_op_write, 16'h0200, 16'hF800, 1, 0, "busy store");
		rd(0, 16'hF900, 1, "stall fetch");
		rd(0, ta, 0, "rww fetch");
		rd(1, ta, 0, "rww load");
		fin();
		$display("test rww done");
		for (int g = 1; g <= 4; g++)
		begin
			ta = 16'hF000 | 16'($urandom_range(0, 16'h0FFF));
			st(fspg_pkg::fspg_op_write, ta, 16'hF800, g, 1, "stall write");
			`CHK("halt", 1'b1, core_halt)
			rd(0, 16'hF800, 0, "halted fetch");
			fin();
		end
		$display("test stall done");
		for (int f = 0; f < 4; f++)
		begin
			@(posedge clock);
			boot_size_fuses <= 2'(f);
			st(fspg_pkg::fspg_op_erase, 16'h0100, base(2'(f)) - 16'h1, 1, 0, "app store");
			st(fspg_pkg::fspg_op_erase, 16'h0100, base(2'(f)), 1, 1, "boot store");
			fin();
		end
		st(fspg_pkg::fspg_op_erase, 16'h0100, 16'hFF00, 5, 0, "late store");
		// lock bits by store: refused from application code, ANDed in from boot code
		slock(4'h0, 16'h0400, 4'hF, "app lock store");
		slock(4'hE, 16'hFF00, 4'hE, "boot lock store");
		st(fspg_pkg::fspg_op_write, 16'h0200, 16'hFF00, 1, 0, "stored lock");
		$display("test fuses done");
		for (int m = 0; m < 4; m++)
		begin
			lv = 2'(m);
			@(posedge clock);
			general_lock_mode <= 2'($urandom);
			lock({lv, lv});
			st(fspg_pkg::fspg_op_write, 16'h0200, 16'hFF00, 2, lv[0], "app lock");
			if (lv[0])
				fin();
			st(fspg_pkg::fspg_op_write, 16'hFE00, 16'hFF00, 3, lv[0], "boot lock");
			if (lv[0])
				fin();
			rd(1, 16'h0300, lv[1], "boot loads app");
			irq(1, 16'h0400, lv[1], "irq in app");
			rd(1, 16'hFF00, lv[1], "app loads boot");
			irq(0, 16'hFF00, lv[1], "irq in boot");
		end
		$display("test locks done");
		final_report();
	end
	// watchdog well beyond the expected run
	initial
	begin
		#200000;
		failures++;
		final_report();
	end
endmodule
